/* design/crss_pkg.sv */
// Package for the core readiness and setup sequencer: constants, types, register map.
// Summary of operation
// - Power-up reset holds fabric and core in reset, all output buffers high-impedance.
// - Power-up reset clears every core flip-flop except boundary-scan shift registers; the local bus and pad hold flip-flops reset high.
// - During fabric configuration core stays in reset, local bus signals forced high.
// - During configuration protection selects, overhead clock gate, frame pulses forced low.
// - Core-ready output stays low throughout fabric configuration.
// - Core-ready stays low six clocks after done, I/O release, core reset high.
// - After that delay core-ready goes high; core may talk to fabric.
// - Full reconfiguration drops core-ready, then the release sequence repeats.
// - Partial reconfiguration leaves core-ready asserted.
// - Core options reachable over system bus from host port or fabric master.
`default_nettype none
package crss_pkg;
	localparam int CRSS_NUM_CH = 8;
	localparam int CRSS_ADDR_W = 18;
	localparam int CRSS_DATA_W = 8;
	localparam int CRSS_CLOCK_MHZ = 10;
	// Release delay is given in clock cycles of the bus side clock
	localparam int CRSS_READY_DELAY_CYCLES = 6;
	localparam logic [CRSS_ADDR_W-1:0] CRSS_STATUS_ADDR = 18'h30000;
	localparam logic [CRSS_ADDR_W-1:0] CRSS_KEY1_ADDR = 18'h30004;
	localparam logic [CRSS_ADDR_W-1:0] CRSS_KEY2_ADDR = 18'h30005;
	localparam logic [CRSS_DATA_W-1:0] CRSS_KEY1_VALUE = 8'h05;
	localparam logic [CRSS_DATA_W-1:0] CRSS_KEY2_VALUE = 8'h80;
	localparam logic [CRSS_DATA_W-1:0] CRSS_REG_RESET = 8'h00;
	localparam logic [CRSS_DATA_W-1:0] CRSS_MODE_FUNCTIONAL = 8'h07;
	localparam logic [CRSS_DATA_W-1:0] CRSS_OH_TRANSPARENT = 8'hFF;
	localparam int CRSS_ST_UNLOCKED_BIT = 0;
	localparam int CRSS_ST_KEY1_BIT = 1;
	localparam int CRSS_ST_READY_BIT = 2;
	localparam logic [CRSS_ADDR_W-1:0] CRSS_MODE_ADDR [CRSS_NUM_CH] = '{
		18'h30020, 18'h30038, 18'h30050, 18'h30068,
		18'h30080, 18'h30098, 18'h300B0, 18'h300C8};
	localparam logic [CRSS_ADDR_W-1:0] CRSS_OH_A_ADDR [CRSS_NUM_CH] = '{
		18'h30021, 18'h30030, 18'h30051, 18'h30069,
		18'h30081, 18'h30099, 18'h300B1, 18'h300C9};
	localparam logic [CRSS_ADDR_W-1:0] CRSS_OH_B_ADDR [CRSS_NUM_CH] = '{
		18'h30022, 18'h3003A, 18'h30052, 18'h3006A,
		18'h30082, 18'h3009A, 18'h300B2, 18'h300CA};

	typedef struct packed {
		logic [3:0] protection_select;
		logic       tx_overhead_clock_gate;
		logic       system_frame_pulse;
		logic       line_frame_pulse;
	} crss_fabric_ctl_type;

	typedef enum logic [1:0] {
		CRSS_HOLD,
		CRSS_COUNT,
		CRSS_READY
	} crss_state_type;
endpackage
`default_nettype wire

/* design/crss_core.sv */
// Core readiness sequencer, fabric-side forcing and locked setup register file.
`timescale 1ns/1ps
`default_nettype none
module crss_core import crss_pkg::*; #(
	parameter int LOCAL_BUS_W = 16,
	parameter int PAD_W       = 8,
	parameter int READY_DELAY = CRSS_READY_DELAY_CYCLES
) (
	input  wire logic                         i_clock,
	input  wire logic                         i_rst_b,
	input  wire logic                         i_config_done,
	input  wire logic                         i_io_release,
	input  wire logic                         i_core_rst_b,
	input  wire logic                         i_partial_config,
	input  wire logic [LOCAL_BUS_W-1:0]       i_core_local_bus,
	input  wire crss_fabric_ctl_type          i_core_fabric_ctl,
	input  wire logic [PAD_W-1:0]             i_core_pad_oe_b,
	input  wire logic                         i_bus_sel,
	input  wire logic                         i_bus_wr,
	input  wire logic [CRSS_ADDR_W-1:0]       i_bus_addr,
	input  wire logic [CRSS_DATA_W-1:0]       i_bus_wdata,
	output logic      [CRSS_DATA_W-1:0]       o_bus_rdata,
	output logic                              o_bus_ack,
	output logic                              o_core_ready,
	output logic                              o_core_rst_b,
	output logic      [LOCAL_BUS_W-1:0]       o_local_bus,
	output crss_fabric_ctl_type               o_fabric_ctl,
	output logic      [PAD_W-1:0]             o_pad_oe_b,
	output logic                              o_unlocked,
	output logic [CRSS_NUM_CH-1:0][CRSS_DATA_W-1:0] o_ch_mode,
	output logic [CRSS_NUM_CH-1:0][CRSS_DATA_W-1:0] o_ch_oh_a,
	output logic [CRSS_NUM_CH-1:0][CRSS_DATA_W-1:0] o_ch_oh_b
);

	localparam int CNT_W = 8;
	localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(READY_DELAY - 1);

	generate
		if (READY_DELAY < 2 || READY_DELAY > 255) begin : g_bad_delay
			$error("READY_DELAY must lie in 2..255");
		end
		if (LOCAL_BUS_W < 1 || PAD_W < 1) begin : g_bad_width
			$error("LOCAL_BUS_W and PAD_W must be at least 1");
		end
	endgenerate

	// Register kinds of one channel
	localparam logic [1:0] KIND_NONE = 2'h0;
	localparam logic [1:0] KIND_MODE = 2'h1;
	localparam logic [1:0] KIND_OH_A = 2'h2;
	localparam logic [1:0] KIND_OH_B = 2'h3;

	// Returns {kind, channel}; channel registers are scattered, so a table walk
	function automatic logic [4:0] ch_decode(input logic [CRSS_ADDR_W-1:0] addr);
		logic [4:0] res;
		res = {KIND_NONE, 3'h0};
		for (int c = 0; c < CRSS_NUM_CH; c++) begin
			if (addr == CRSS_MODE_ADDR[c]) begin
				res = {KIND_MODE, 3'(c)};
			end else if (addr == CRSS_OH_A_ADDR[c]) begin
				res = {KIND_OH_A, 3'(c)};
			end else if (addr == CRSS_OH_B_ADDR[c]) begin
				res = {KIND_OH_B, 3'(c)};
			end
		end
		return res;
	endfunction

	crss_state_type state;
	crss_state_type next_state;
	logic [CNT_W-1:0] cnt;
	logic             pwr_hold;
	logic             all_high;
	logic             full_reconfig;
	logic             next_ready;

	assign all_high = i_config_done && i_io_release && i_core_rst_b;
	// Partial configuration keeps done/io-release meaningless, so it cannot drop ready
	assign full_reconfig = !i_partial_config && (!i_config_done || !i_io_release);
	assign next_ready = (next_state == CRSS_READY);

	always_comb begin
		next_state = state;
		case (state)
			CRSS_HOLD: begin
				if (all_high) begin
					next_state = CRSS_COUNT;
				end
			end
			CRSS_COUNT: begin
				if (!all_high) begin
					next_state = CRSS_HOLD;
				end else if (cnt == CNT_LAST) begin
					next_state = CRSS_READY;
				end
			end
			CRSS_READY: begin
				if (full_reconfig) begin
					next_state = CRSS_HOLD;
				end else if (!i_core_rst_b && !i_partial_config) begin
					next_state = CRSS_HOLD;
				end
			end
			default: begin
				next_state = CRSS_HOLD;
			end
		endcase
	end

	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			state <= CRSS_HOLD;
		end else begin
			state <= next_state;
		end
	end

	// Counts edges with all release inputs high, the entry edge included, so
	// ready rises on the sixth such edge; restarts on any glitch
	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			cnt <= '0;
		end else if (next_state == CRSS_COUNT) begin
			cnt <= cnt + CNT_W'(1);
		end else begin
			cnt <= '0;
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_core_ready <= 1'b0;
		end else begin
			o_core_ready <= next_ready;
		end
	end

	// Core logic leaves reset once release inputs are high, ahead of ready
	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_core_rst_b <= 1'b0;
		end else begin
			o_core_rst_b <= (next_state != CRSS_HOLD);
		end
	end

	// Fabric-facing signals stay forced until ready, so the fabric sees no
	// half-initialised values in the six-cycle window either
	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_local_bus <= '1;
		end else if (next_ready) begin
			o_local_bus <= i_core_local_bus;
		end else begin
			o_local_bus <= '1;
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_fabric_ctl <= '0;
		end else if (next_ready) begin
			o_fabric_ctl <= i_core_fabric_ctl;
		end else begin
			o_fabric_ctl <= '0;
		end
	end

	// Pads float until the first clock after power-up reset is released
	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			pwr_hold <= 1'b1;
		end else begin
			pwr_hold <= 1'b0;
		end
	end

	assign o_pad_oe_b = pwr_hold ? '1 : i_core_pad_oe_b;

	// Register bus
	logic       wr_req;
	logic       rd_req;
	logic [4:0] dec;
	logic [1:0] dec_kind;
	logic [2:0] dec_ch;
	logic [CRSS_DATA_W-1:0] key1;
	logic [CRSS_DATA_W-1:0] key2;
	logic       key1_ok;
	logic [CRSS_DATA_W-1:0] next_rdata;

	assign wr_req = i_bus_sel && i_bus_wr;
	assign rd_req = i_bus_sel && !i_bus_wr;
	assign dec = ch_decode(i_bus_addr);
	assign dec_kind = dec[4:3];
	assign dec_ch = dec[2:0];

	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			key1 <= CRSS_REG_RESET;
		end else if (wr_req && i_bus_addr == CRSS_KEY1_ADDR) begin
			key1 <= i_bus_wdata;
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			key2 <= CRSS_REG_RESET;
		end else if (wr_req && i_bus_addr == CRSS_KEY2_ADDR) begin
			key2 <= i_bus_wdata;
		end
	end

	// First key must land before the second; any other first-key value disarms
	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			key1_ok <= 1'b0;
		end else if (wr_req && i_bus_addr == CRSS_KEY1_ADDR) begin
			key1_ok <= (i_bus_wdata == CRSS_KEY1_VALUE);
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_unlocked <= 1'b0;
		end else if (wr_req && i_bus_addr == CRSS_KEY1_ADDR) begin
			o_unlocked <= 1'b0;
		end else if (wr_req && i_bus_addr == CRSS_KEY2_ADDR) begin
			o_unlocked <= key1_ok && (i_bus_wdata == CRSS_KEY2_VALUE);
		end
	end

	generate
		for (genvar c = 0; c < CRSS_NUM_CH; c++) begin : g_ch
			logic hit;
			assign hit = wr_req && o_unlocked && (dec_ch == 3'(c));

			always_ff @(posedge i_clock or negedge i_rst_b) begin
				if (!i_rst_b) begin
					o_ch_mode[c] <= CRSS_REG_RESET;
				end else if (hit && dec_kind == KIND_MODE) begin
					o_ch_mode[c] <= i_bus_wdata;
				end
			end

			always_ff @(posedge i_clock or negedge i_rst_b) begin
				if (!i_rst_b) begin
					o_ch_oh_a[c] <= CRSS_REG_RESET;
				end else if (hit && dec_kind == KIND_OH_A) begin
					o_ch_oh_a[c] <= i_bus_wdata;
				end
			end

			always_ff @(posedge i_clock or negedge i_rst_b) begin
				if (!i_rst_b) begin
					o_ch_oh_b[c] <= CRSS_REG_RESET;
				end else if (hit && dec_kind == KIND_OH_B) begin
					o_ch_oh_b[c] <= i_bus_wdata;
				end
			end
		end
	endgenerate

	// Unmapped addresses read as zero
	always_comb begin
		next_rdata = '0;
		if (i_bus_addr == CRSS_STATUS_ADDR) begin
			next_rdata[CRSS_ST_UNLOCKED_BIT] = o_unlocked;
			next_rdata[CRSS_ST_KEY1_BIT] = key1_ok;
			next_rdata[CRSS_ST_READY_BIT] = o_core_ready;
		end else if (i_bus_addr == CRSS_KEY1_ADDR) begin
			next_rdata = key1;
		end else if (i_bus_addr == CRSS_KEY2_ADDR) begin
			next_rdata = key2;
		end else if (dec_kind == KIND_MODE) begin
			next_rdata = o_ch_mode[dec_ch];
		end else if (dec_kind == KIND_OH_A) begin
			next_rdata = o_ch_oh_a[dec_ch];
		end else if (dec_kind == KIND_OH_B) begin
			next_rdata = o_ch_oh_b[dec_ch];
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_bus_rdata <= '0;
		end else if (rd_req) begin
			o_bus_rdata <= next_rdata;
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_bus_ack <= 1'b0;
		end else begin
			o_bus_ack <= i_bus_sel;
		end
	end

endmodule // crss_core
`default_nettype wire

/* verification/crss_setup_master.sv */
// Setup master model: register accesses and the unlock and channel setup sequence.
`timescale 1ns/1ps
`default_nettype none
module crss_setup_master import crss_pkg::*; #(
	parameter bit FABRIC_PORT = 1'b0
) (
	input  wire logic                   i_clock,
	input  wire logic [CRSS_DATA_W-1:0] i_bus_rdata,
	output var  logic                   o_bus_sel,
	output var  logic                   o_bus_wr,
	output var  logic [CRSS_ADDR_W-1:0] o_bus_addr,
	output var  logic [CRSS_DATA_W-1:0] o_bus_wdata
);
	initial begin
		o_bus_sel = 1'b0;
		o_bus_wr = 1'b0;
		o_bus_addr = '0;
		o_bus_wdata = 8'hA5;
	end
	// Each sel cycle is one access, so sel stays up for one edge only
	task automatic access(input logic wr, input logic [CRSS_ADDR_W-1:0] addr,
		input logic [CRSS_DATA_W-1:0] data, output logic [CRSS_DATA_W-1:0] rd);
		@(negedge i_clock);
		o_bus_sel = 1'b1;
		o_bus_wr = wr;
		o_bus_addr = addr;
		o_bus_wdata = data;
		@(negedge i_clock);
		rd = i_bus_rdata;
		o_bus_sel = 1'b0;
		// Released data no longer shows the last value
		o_bus_wdata = ~data;
	endtask
	// A fabric port master reverses byte order; one-byte values pass unchanged
	function automatic logic [CRSS_DATA_W-1:0] lane_order(input logic [CRSS_DATA_W-1:0] v);
		logic [CRSS_DATA_W-1:0] r;
		r = v;
		if (FABRIC_PORT) begin
			for (int b = 0; b < CRSS_DATA_W / 8; b++) begin
				r[8*b +: 8] = v[CRSS_DATA_W-8-8*b +: 8];
			end
		end
		return r;
	endfunction
	// Register configuration step, values used as listed in this order
	task automatic setup();
		logic [CRSS_DATA_W-1:0] rd;
		access(1'b1, CRSS_KEY1_ADDR, lane_order(CRSS_KEY1_VALUE), rd);
		access(1'b1, CRSS_KEY2_ADDR, lane_order(CRSS_KEY2_VALUE), rd);
		for (int c = 0; c < CRSS_NUM_CH; c++) begin
			access(1'b1, CRSS_MODE_ADDR[c], lane_order(CRSS_MODE_FUNCTIONAL), rd);
			access(1'b1, CRSS_OH_A_ADDR[c], lane_order(CRSS_OH_TRANSPARENT), rd);
			access(1'b1, CRSS_OH_B_ADDR[c], lane_order(CRSS_OH_TRANSPARENT), rd);
		end
	endtask
endmodule // crss_setup_master
`default_nettype wire

/* verification/crss_checker.sv */
// Checker for readiness timing, forced fabric outputs and the register lock.
`timescale 1ns/1ps
`default_nettype none
module crss_checker import crss_pkg::*; #(
	parameter int LOCAL_BUS_W = 16,
	parameter int READY_DELAY = CRSS_READY_DELAY_CYCLES
) (
	input wire logic                                   i_clock,
	input wire logic                                   i_rst_b,
	input wire logic                                   i_config_done,
	input wire logic                                   i_io_release,
	input wire logic                                   i_core_rst_b,
	input wire logic                                   i_partial_config,
	input wire logic [LOCAL_BUS_W-1:0]                 i_core_local_bus,
	input wire crss_fabric_ctl_type                    i_core_fabric_ctl,
	input wire logic                                   i_bus_sel,
	input wire logic                                   i_bus_wr,
	input wire logic [CRSS_ADDR_W-1:0]                 i_bus_addr,
	input wire logic [CRSS_DATA_W-1:0]                 i_bus_wdata,
	input wire logic                                   o_bus_ack,
	input wire logic                                   o_core_ready,
	input wire logic [LOCAL_BUS_W-1:0]                 o_local_bus,
	input wire crss_fabric_ctl_type                    o_fabric_ctl,
	input wire logic                                   o_unlocked,
	input wire logic [CRSS_NUM_CH-1:0][CRSS_DATA_W-1:0] o_ch_mode
);
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_rst_b);
	logic       rel;
	logic [3:0] run;
	assign rel = i_config_done && i_io_release && i_core_rst_b;
	// Saturates so a long steady run cannot wrap back to a small count
	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) run <= '0;
		else run <= rel ? (run == 4'hF ? run : run + 4'h1) : 4'h0;
	end
	sequence key1_wr;
		i_bus_sel && i_bus_wr && i_bus_addr == CRSS_KEY1_ADDR && i_bus_wdata == CRSS_KEY1_VALUE;
	endsequence
	sequence key2_wr;
		i_bus_sel && i_bus_wr && i_bus_addr == CRSS_KEY2_ADDR && i_bus_wdata == CRSS_KEY2_VALUE;
	endsequence
	chk_ready_late: assert property ((!o_core_ready && rel) ##1 rel [*5] |=> o_core_ready)
		else $error("core ready late");
	chk_ready_early: assert property ($rose(o_core_ready) |-> run == 4'(READY_DELAY))
		else $error("core ready count wrong");
	chk_forced_out: assert property (!o_core_ready |-> o_local_bus == '1 && o_fabric_ctl == '0)
		else $error("fabric outputs not forced");
	chk_pass_out: assert property (o_core_ready |->
		o_local_bus == $past(i_core_local_bus) && o_fabric_ctl == $past(i_core_fabric_ctl))
		else $error("fabric outputs not passed");
	chk_full_drop: assert property (o_core_ready && !i_partial_config && !rel |=> !o_core_ready)
		else $error("ready kept on reconfig");
	chk_partial_keep: assert property (o_core_ready && i_partial_config |=> o_core_ready)
		else $error("ready lost on partial");
	chk_bus_ack: assert property (o_bus_ack == $past(i_bus_sel))
		else $error("ack timing wrong");
	chk_locked_regs: assert property (!o_unlocked && i_bus_sel && i_bus_wr |=> $stable(o_ch_mode))
		else $error("locked write took effect");
	chk_unlock_seq: assert property (key1_wr ##1 !i_bus_sel ##1 key2_wr |=> o_unlocked)
		else $error("keys did not unlock");
	chk_mode_write: assert property (o_unlocked && i_bus_sel && i_bus_wr &&
		i_bus_addr == CRSS_MODE_ADDR[0] |=> o_ch_mode[0] == $past(i_bus_wdata))
		else $error("mode write lost");
endmodule // crss_checker
bind crss_core crss_checker #(.LOCAL_BUS_W(LOCAL_BUS_W), .READY_DELAY(READY_DELAY)) crss_checker_i (
	.i_clock(i_clock), .i_rst_b(i_rst_b), .i_config_done(i_config_done),
	.i_io_release(i_io_release), .i_core_rst_b(i_core_rst_b), .i_partial_config(i_partial_config),
	.i_core_local_bus(i_core_local_bus), .i_core_fabric_ctl(i_core_fabric_ctl),
	.i_bus_sel(i_bus_sel), .i_bus_wr(i_bus_wr), .i_bus_addr(i_bus_addr), .i_bus_wdata(i_bus_wdata),
	.o_bus_ack(o_bus_ack), .o_core_ready(o_core_ready), .o_local_bus(o_local_bus),
	.o_fabric_ctl(o_fabric_ctl), .o_unlocked(o_unlocked), .o_ch_mode(o_ch_mode));
`default_nettype wire

/* verification/testbench.sv */
// Testbench for the core readiness and setup sequencer.
`timescale 1ns/1ps
`default_nettype none
module testbench import crss_pkg::*;;
	typedef struct {logic [CRSS_ADDR_W-1:0] addr; logic [CRSS_DATA_W-1:0] exp;} crss_row_type;
	logic clock, rst_b, done, io_rel, core_rst_b, partial, sel, wr, ack, ready, core_rst_out, unlocked;
	logic [15:0] local_in, local_bus;
	logic [7:0] pad_in, pad_oe_b, wdata, rdata, rd;
	logic [CRSS_ADDR_W-1:0] addr;
	crss_fabric_ctl_type ctl_in, fabric_ctl;
	logic [CRSS_NUM_CH-1:0][CRSS_DATA_W-1:0] ch_mode, ch_oh_a, ch_oh_b;
	crss_row_type rows [3*CRSS_NUM_CH+4];
	int fails = 0;
	int checks = 0;
	crss_core #(.LOCAL_BUS_W(16), .PAD_W(8), .READY_DELAY(6)) crss_core_i (.i_clock(clock),
		.i_rst_b(rst_b), .i_config_done(done), .i_io_release(io_rel), .i_core_rst_b(core_rst_b),
		.i_partial_config(partial), .i_core_local_bus(local_in), .i_core_fabric_ctl(ctl_in),
		.i_core_pad_oe_b(pad_in), .i_bus_sel(sel), .i_bus_wr(wr), .i_bus_addr(addr),
		.i_bus_wdata(wdata), .o_bus_rdata(rdata), .o_bus_ack(ack), .o_core_ready(ready),
		.o_core_rst_b(core_rst_out), .o_local_bus(local_bus), .o_fabric_ctl(fabric_ctl),
		.o_pad_oe_b(pad_oe_b), .o_unlocked(unlocked), .o_ch_mode(ch_mode), .o_ch_oh_a(ch_oh_a),
		.o_ch_oh_b(ch_oh_b));
	crss_setup_master crss_setup_master_i (.i_clock(clock), .i_bus_rdata(rdata),
		.o_bus_sel(sel), .o_bus_wr(wr), .o_bus_addr(addr), .o_bus_wdata(wdata));
	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	// Ready must stay low across five edges with all three inputs high and be up after the sixth
	task automatic release_and_check();
		@(negedge clock);
		{done, io_rel, core_rst_b} = 3'b111;
		repeat (6) begin
			check({ready, fabric_ctl, 8'h00}, 16'h0000);
			check(local_bus, 16'hFFFF);
			@(negedge clock);
		end
		check({ready, core_rst_out, 14'h0000}, 16'hC000);
		check(local_bus, local_in);
		check(16'(fabric_ctl), 16'(ctl_in));
	endtask
	initial begin
		{rst_b, done, io_rel, core_rst_b, partial} = 5'h00;
		local_in = 16'h1234;
		ctl_in = crss_fabric_ctl_type'(7'h5B);
		pad_in = 8'h3C;
		repeat (3) @(negedge clock);
		check(16'(pad_oe_b), 16'h00FF);
		check({ready, core_rst_out, unlocked, 5'h00, ch_mode[0]}, 16'h0000);
		rst_b = 1'b1;
		@(negedge clock);
		check(16'(pad_oe_b), 16'h003C);
		release_and_check();
		// Locked write, then the keys in the wrong order
		crss_setup_master_i.access(1'b1, CRSS_MODE_ADDR[0], CRSS_MODE_FUNCTIONAL, rd);
		crss_setup_master_i.access(1'b1, CRSS_KEY2_ADDR, CRSS_KEY2_VALUE, rd);
		crss_setup_master_i.access(1'b1, CRSS_KEY1_ADDR, CRSS_KEY1_VALUE, rd);
		crss_setup_master_i.access(1'b1, CRSS_MODE_ADDR[1], CRSS_MODE_FUNCTIONAL, rd);
		check({ch_mode[0], ch_mode[1]}, 16'h0000);
		check(16'(unlocked), 16'h0000);
		crss_setup_master_i.setup();
		rows[0] = '{CRSS_KEY1_ADDR, CRSS_KEY1_VALUE};
		rows[1] = '{CRSS_KEY2_ADDR, CRSS_KEY2_VALUE};
		rows[2] = '{18'h3FFFF, 8'h00};
		rows[3*CRSS_NUM_CH+3] = '{CRSS_STATUS_ADDR, 8'((1 << CRSS_ST_UNLOCKED_BIT) |
			(1 << CRSS_ST_KEY1_BIT) | (1 << CRSS_ST_READY_BIT))};
		for (int c = 0; c < CRSS_NUM_CH; c++) begin
			rows[3+3*c] = '{CRSS_MODE_ADDR[c], CRSS_MODE_FUNCTIONAL};
			rows[4+3*c] = '{CRSS_OH_A_ADDR[c], CRSS_OH_TRANSPARENT};
			rows[5+3*c] = '{CRSS_OH_B_ADDR[c], CRSS_OH_TRANSPARENT};
		end
		foreach (rows[i]) begin
			crss_setup_master_i.access(1'b0, rows[i].addr, 8'h00, rd);
			check(16'(rd), 16'(rows[i].exp));
		end
		check({ch_oh_a[1], ch_oh_b[7]}, 16'hFFFF);
		partial = 1'b1;
		done = 1'b0;
		repeat (3) @(negedge clock);
		check(16'(ready), 16'h0001);
		partial = 1'b0;
		@(negedge clock);
		check({ready, core_rst_out, 6'h00, ch_mode[7]}, 16'h0007);
		release_and_check();
		// Core global reset alone also withdraws ready
		core_rst_b = 1'b0;
		@(negedge clock);
		check({ready, core_rst_out, 14'h0000}, 16'h0000);
		rst_b = 1'b0;
		@(negedge clock);
		check({unlocked, 7'h00, ch_mode[0]}, 16'h0000);
		report_and_stop();
	end
	initial begin
		#100000;
		fails++;
		report_and_stop();
	end
endmodule // testbench
`default_nettype wire
